// File: verilog/acl_pkg.sv
// Purpose: Shared constants and types for the async control word low byte
// Assumes: Word-wide register access only
// Notes: Field positions follow the control word layout

package acl_pkg;

    // Control word field positions
    localparam int PTR_LSB = 0;
    localparam int PTR_W = 5;
    localparam int RST_BIT = 5;
    localparam int RIE_BIT = 6;
    localparam int RDA_BIT = 7;
    localparam int WORD_W = 16;

    // Silo and threshold figures
    localparam int SILO_DEPTH = 48;
    localparam int FILL_LIMIT = 16;
    localparam int CNT_W = 6;
    localparam int TMO_W = 16;

    // Software reset length in clocks
    localparam int SRST_CYCLES = 8;
    localparam int SRST_W = 4;

    localparam logic [PTR_W-1:0] PTR_RESET = 5'h00;

    // Register access from the bus side
    typedef struct packed {
        logic wr;
        logic rd;
        logic [WORD_W-1:0] wdata;
    } acl_bus_req_t;

    // Silo status from the receive side
    typedef struct packed {
        logic not_empty;
        logic [CNT_W-1:0] fill;
        logic char_in;
    } acl_silo_t;

endpackage : acl_pkg

// File: verilog/acl_rx_alarm.sv
// Purpose: Receive interrupt request from silo age and count of characters entered
// Assumes: Silo status arrives on the module clock
// Notes: Timeout restarts whenever the silo is read

`timescale 1ns/1ps
`default_nettype none

module acl_rx_alarm #(
    parameter int TMO_W = acl_pkg::TMO_W,
    parameter int CNT_W = acl_pkg::CNT_W,
    parameter int FILL_LIMIT = acl_pkg::FILL_LIMIT
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic clear_in,
    // Controls
    input wire logic enable_in,
    input wire logic avail_in,
    input wire logic silo_read_in,
    input wire logic char_in_in,
    input wire logic [TMO_W-1:0] timeout_in,
    // Request
    output logic req_out
);

    logic [TMO_W-1:0] age_ff;
    logic [CNT_W:0] entered_ff;
    logic aged;
    logic filled;

    // Age counts while data sits unread
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            age_ff <= '0;
        end else if (clear_in || !avail_in || silo_read_in) begin
            age_ff <= '0;
        end else if (age_ff != {TMO_W{1'b1}}) begin
            age_ff <= age_ff + 1'b1;
        end
    end

    // Characters entered since the silo last emptied
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            entered_ff <= '0;
        end else if (clear_in || !avail_in) begin
            entered_ff <= '0;
        end else if (char_in_in && entered_ff != {(CNT_W+1){1'b1}}) begin
            entered_ff <= entered_ff + 1'b1;
        end
    end

    assign aged = avail_in && (age_ff > timeout_in);
    assign filled = entered_ff > (CNT_W+1)'(FILL_LIMIT);

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            req_out <= 1'b0;
        end else begin
            req_out <= !clear_in && enable_in && (aged || filled);
        end
    end

endmodule : acl_rx_alarm

`default_nettype wire

// File: verilog/acl_ctrl.sv
// Purpose: Low byte of the async mux control word with receive interrupt
// Assumes: Bus init and silo status are synchronous to ref_clk_in
// Notes: Upper byte reads as zero here
//
// Overview of operation
// - Five-bit pointer selects one of 32 registers
// - Pointer cleared by soft reset or init
// - Reset bit starts reset, reads one, self-clears
// - Reset bit write during reset is ignored
// - Enabled request when data waits past timeout
// - Enabled request when over 16 characters entered
// - Interrupt enable read/write, cleared by resets
// - Data available set when silo holds entry
// - Data available clears when silo empties
// - Data available read-only, cleared by resets
// - Whole-word access only, no read-modify-write
// - Timeout comes from silo parameter register
// - One shared 48-entry silo feeds flags

`timescale 1ns/1ps
`default_nettype none

module acl_ctrl #(
    parameter int SRST_CYCLES = acl_pkg::SRST_CYCLES,
    parameter int TMO_W = acl_pkg::TMO_W
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic bus_init_in,
    // Register access
    input wire acl_pkg::acl_bus_req_t bus_in,
    output logic [acl_pkg::WORD_W-1:0] rdata_out,
    // Receive silo side
    input wire acl_pkg::acl_silo_t silo_in,
    input wire logic silo_read_in,
    input wire logic [TMO_W-1:0] timeout_in,
    // Results
    output logic [acl_pkg::PTR_W-1:0] ptr_out,
    output logic soft_reset_out,
    output logic rx_irq_out
);

    logic [acl_pkg::PTR_W-1:0] ptr_ff;
    logic rie_ff;
    logic rda_ff;
    logic srst_ff;
    logic [acl_pkg::SRST_W-1:0] srst_cnt_ff;
    logic clr;
    logic srst_done;
    logic alarm;

    // Either reset source clears the low-byte state
    assign clr = bus_init_in || srst_ff;
    assign srst_done = srst_cnt_ff == acl_pkg::SRST_W'(SRST_CYCLES - 1);

    // Pointer holds until written whole
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ptr_ff <= acl_pkg::PTR_RESET;
        end else if (clr) begin
            ptr_ff <= acl_pkg::PTR_RESET;
        end else if (bus_in.wr) begin
            ptr_ff <= bus_in.wdata[acl_pkg::PTR_LSB +: acl_pkg::PTR_W];
        end
    end

    // Software reset runs a fixed count; rewrites during it do nothing
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            srst_ff <= 1'b0;
            srst_cnt_ff <= '0;
        end else if (bus_init_in) begin
            srst_ff <= 1'b0;
            srst_cnt_ff <= '0;
        end else if (srst_ff) begin
            srst_cnt_ff <= srst_cnt_ff + 1'b1;
            if (srst_done) begin
                srst_ff <= 1'b0;
                srst_cnt_ff <= '0;
            end
        end else if (bus_in.wr && bus_in.wdata[acl_pkg::RST_BIT]) begin
            srst_ff <= 1'b1;
        end
    end

    // Receive interrupt enable
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rie_ff <= 1'b0;
        end else if (clr) begin
            rie_ff <= 1'b0;
        end else if (bus_in.wr) begin
            rie_ff <= bus_in.wdata[acl_pkg::RIE_BIT];
        end
    end

    // Data available follows the shared silo; writes never reach it
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rda_ff <= 1'b0;
        end else if (clr) begin
            rda_ff <= 1'b0;
        end else begin
            rda_ff <= silo_in.not_empty;
        end
    end

    acl_rx_alarm #(
        .TMO_W(TMO_W),
        .CNT_W(acl_pkg::CNT_W),
        .FILL_LIMIT(acl_pkg::FILL_LIMIT)
    ) u_alarm (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .clear_in(clr),
        .enable_in(rie_ff),
        .avail_in(rda_ff),
        .silo_read_in(silo_read_in),
        .char_in_in(silo_in.char_in),
        .timeout_in(timeout_in),
        .req_out(alarm)
    );

    // Registered read data and outputs
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= '0;
            ptr_out <= acl_pkg::PTR_RESET;
            soft_reset_out <= 1'b0;
            rx_irq_out <= 1'b0;
        end else begin
            rdata_out <= '0;
            rdata_out[acl_pkg::PTR_LSB +: acl_pkg::PTR_W] <= ptr_ff;
            rdata_out[acl_pkg::RST_BIT] <= srst_ff;
            rdata_out[acl_pkg::RIE_BIT] <= rie_ff;
            rdata_out[acl_pkg::RDA_BIT] <= rda_ff;
            ptr_out <= ptr_ff;
            soft_reset_out <= srst_ff;
            rx_irq_out <= alarm && rie_ff;
        end
    end

endmodule : acl_ctrl

`default_nettype wire

// File: verif/acl_ctrl_asserts.sv
// Purpose: Port assertions for the control word low byte
// Assumes: Soft reset runs 8 clocks
// Notes: Bound to acl_ctrl
`timescale 1ns/1ps
`default_nettype none
module acl_ctrl_asserts (
    // Watched ports
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic bus_init_in,
    input wire acl_pkg::acl_bus_req_t bus_in,
    input wire acl_pkg::acl_silo_t silo_in,
    input wire logic [15:0] rdata_out,
    input wire logic [4:0] ptr_out,
    input wire logic soft_reset_out,
    input wire logic rx_irq_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    logic [4:0] chars_ff;
    logic wr_rst_ff;
    wire logic idle = !bus_init_in && !soft_reset_out && !wr_rst_ff;
    // Reset bit write shows on soft_reset_out two edges late
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) wr_rst_ff <= 1'b0;
        else wr_rst_ff <= bus_in.wr && bus_in.wdata[5];
    end
    // Saturates so a long burst cannot wrap below the threshold
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) chars_ff <= 5'h00;
        else if (!silo_in.not_empty) chars_ff <= 5'h00;
        else if (silo_in.char_in && chars_ff != 5'h1f) chars_ff <= chars_ff + 5'h01;
    end
    sequence srst_run;
        soft_reset_out [*8];
    endsequence
    a_ptr_write: assert property (bus_in.wr && idle && !bus_in.wdata[5]
        |-> ##2 ptr_out == $past(bus_in.wdata[4:0], 2)) else $error("pointer write lost");
    a_init_clear: assert property (bus_init_in
        |-> ##2 ptr_out == 5'h00 && !soft_reset_out) else $error("init left state");
    a_ptr_held: assert property (soft_reset_out |=> ptr_out == 5'h00)
        else $error("pointer set in soft reset");
    a_srst_len: assert property (bus_in.wr && bus_in.wdata[5] && idle
        |-> ##2 srst_run ##1 !soft_reset_out) else $error("soft reset length wrong");
    a_srst_ignore: assert property (bus_in.wr && bus_in.wdata[5] && soft_reset_out && !bus_init_in
        |-> ##[1:8] !soft_reset_out) else $error("soft reset restarted");
    a_rda_set: assert property ($rose(silo_in.not_empty) && idle |-> ##2 rdata_out[7])
        else $error("data available not set");
    a_rda_clear: assert property ($fell(silo_in.not_empty) |-> ##2 !rdata_out[7])
        else $error("data available not cleared");
    a_irq_gate: assert property (!rdata_out[6] [*4] |-> !rx_irq_out)
        else $error("request while disabled");
    a_fill_irq: assert property (chars_ff > 5'h10 && rdata_out[6] && silo_in.not_empty
        |-> ##[0:3] rx_irq_out) else $error("fill request missing");
endmodule : acl_ctrl_asserts
bind acl_ctrl acl_ctrl_asserts u_chk (.ref_clk_in, .nrst_in, .bus_init_in, .bus_in, .silo_in,
    .rdata_out, .ptr_out, .soft_reset_out, .rx_irq_out);
`default_nettype wire

// File: verif/async_csr_low_byte_control_test.sv
// Purpose: Self-checking bench for the control word low byte
// Assumes: Default soft reset length
// Notes: Inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module async_csr_low_byte_control_test;
    logic clk;
    logic nrst = 1'h0;
    logic init = 1'h0;
    acl_pkg::acl_bus_req_t bus = '0;
    acl_pkg::acl_silo_t silo = '0;
    logic rd = 1'h0;
    logic [15:0] tmo = 16'h0008;
    logic [15:0] rdata;
    logic [4:0] ptr;
    logic srst;
    logic irq;
    logic [15:0] v;
    int miscompares = 0;
    int cmp_count = 0;
    int n;
    acl_ctrl DUT (.ref_clk_in(clk), .nrst_in(nrst), .bus_init_in(init), .bus_in(bus),
        .rdata_out(rdata), .silo_in(silo), .silo_read_in(rd), .timeout_in(tmo),
        .ptr_out(ptr), .soft_reset_out(srst), .rx_irq_out(irq));
    function automatic logic [15:0] exp_word(input logic [15:0] w);
        return {8'h00, 1'h0, w[6], 1'h0, w[4:0]};
    endfunction : exp_word
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask : tick
    // Gap cycle after each write keeps strobes from colliding
    task automatic wr(input logic [15:0] w);
        bus.wr = 1'h1;
        bus.wdata = w;
        tick(1);
        bus.wr = 1'h0;
        tick(1);
    endtask : wr
    task automatic results();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        results();
    end
    initial begin
        void'($urandom(64));
        tick(20);
        nrst = 1'h1;
        tick(2);
        chk(rdata, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            v = 16'($urandom);
            v[5] = 1'h0;
            wr(v);
            chk(rdata, exp_word(v));
        end
        wr(16'hffdf);
        chk(rdata, 16'h005f);
        wr(16'h0075);
        chk(rdata, 16'h0075);
        wr(16'h002a);
        chk(16'(ptr), 16'h0000);
        n = 0;
        while (srst && n < 20) begin
            n++;
            tick(1);
        end
        // Two of the reset cycles pass inside the rewrite
        chk(16'(n), 16'(acl_pkg::SRST_CYCLES - 2));
        tick(1);
        chk(rdata, 16'h0000);
        wr(16'h005f);
        init = 1'h1;
        tick(1);
        init = 1'h0;
        tick(1);
        chk(rdata, 16'h0000);
        tmo = 16'h0004;
        silo.not_empty = 1'h1;
        tick(30);
        chk(rdata, 16'h0080);
        chk(16'(irq), 16'h0000);
        wr(16'h0000);
        chk(rdata, 16'h0080);
        silo.not_empty = 1'h0;
        tick(3);
        chk(rdata, 16'h0000);
        tmo = 16'(8 + $urandom % 8);
        wr(16'h0040);
        silo.not_empty = 1'h1;
        tick(int'(tmo) - 4);
        chk(16'(irq), 16'h0000);
        tick(10);
        chk(16'(irq), 16'h0001);
        tmo = 16'hffff;
        rd = 1'h1;
        tick(1);
        rd = 1'h0;
        tick(3);
        chk(16'(irq), 16'h0000);
        for (int i = 0; i < 17; i++) begin
            silo.char_in = 1'h1;
            tick(1);
            silo.char_in = 1'h0;
            tick(3);
            chk(16'(irq), 16'(i == 16));
        end
        results();
    end
endmodule : async_csr_low_byte_control_test
`default_nettype wire
